// *** verilog/fcr_pkg.sv ***
package fcr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FCR_ADDR_STATUS = 8'hf8;
  localparam logic [7:0] FCR_ADDR_PROTECT = 8'hf9;
  localparam logic [7:0] FCR_ADDR_ERASE = 8'hfa;
  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int FCR_BIT_DEBUG = 7;
  localparam int FCR_BIT_STP = 6;
  localparam int FCR_BIT_WEN = 5;
  localparam int FCR_BIT_READY_FLAG_N = 4;
  localparam int FCR_BIT_REDIR = 3;
  localparam int FCR_BIT_RBP = 2;
  localparam int FCR_BIT_RSV1 = 1;
  localparam int FCR_BIT_RSV0 = 0;
  // ----------------------------------------------------------------
  // Configuration page layout and values
  // ----------------------------------------------------------------
  localparam logic [8:0] FCR_CFG_BOUNDARY = 9'h020;
  localparam logic [8:0] FCR_CFG_RBP = 9'h023;
  localparam logic [8:0] FCR_CFG_DEBUG = 9'h024;
  localparam logic [7:0] FCR_CFG_ERASED = 8'hff;
  localparam logic [7:0] FCR_PAGE_LIMIT = 8'h24;
  localparam logic [7:0] FCR_ERASE_RESET = 8'h00;
  localparam logic [7:0] FCR_BOUNDARY_RESET = 8'hff;
  localparam logic [7:0] FCR_RESERVED_BYTES = 8'h10;
  // ----------------------------------------------------------------
  // Serial command kinds and boot states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FCR_SP_NONE, FCR_SP_WREN, FCR_SP_WRDIS, FCR_SP_STATUS_WRITE_COMMAND,
    FCR_SP_OP, FCR_SP_ERASE_ALL, FCR_SP_SET_RBP, FCR_SP_SET_DEBUG
  } fcr_sp_cmd_type;
  typedef enum {FCR_BOOT_BOUND, FCR_BOOT_RBP, FCR_BOOT_DEBUG, FCR_BOOT_WAIT, FCR_BOOT_RUN}
    fcr_boot_type;
endpackage

// *** verilog/fcr_flash_config.sv ***
// Functional notes
// (R01) Boot copies configuration page bytes into the registers before normal operation.
// (R02) One register set is shared by serial port and microcontroller.
// (R03) Status bit 7 is debug enable, zero until loaded.
// (R04) With protection off, core may set debug enable; nobody clears it by write.
// (R05) Status bit 6 is parity of top 16 data bits, read only.
// (R06) Start-from-protected starts execution at the protected boundary page.
// (R07) Status bit 5 write-enable latch, reset 0, gates external writes/erases. Code grants non-erase serial ops without the latch.
// (R08) Serial writes/erases clear the latch; core operations leave it.
// (R09) Status bit 4 active-low ready, reset 1, drops when boot readout ends.
// (R10) Status bit 3 redirects serial read/write/erase to the configuration page.
// (R11) Erase-everything erases main block and page regardless of redirect.
// (R12) Status bit 2 readback protect, reset 1, blocks external main block access.
// (R13) Only erase-everything returns protection to full access.
// (R14) Debug and protect bits change only via page or dedicated serial commands; core writes can also set debug when unprotected.
// (R15) Protect register is read only; bits 6:0 boundary page.
// (R16) Boundary below 36 reserves the top 16 main block bytes.
// (R17) Erase register resets 0; core write below 36 erases that page.
// (R18) Brown-out during a flash write aborts it and forces reset.
// (R19) Boundary byte at page offset 0x20 loads protect register; 0xff unprotected.
// (R20) Byte at 0x24 gives debug enable; 0xff means disabled.
// (R21) Byte at 0x23 gives readback protection; 0xff means accessible.
// (R22) Writes to read-only bits are ignored without side effect.
// (R23) Before boot completes, loaded bits keep reset values; no external writes. Code loads protect register two cycles and bit 2 one cycle early.
`timescale 1ns/1ns
module fcr_flash_config (
  input wire logic clk_sys,
  input wire logic reset,
  // Core register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Serial programming port, one command pulse at a time
  input wire logic sp_valid,
  input wire fcr_pkg::fcr_sp_cmd_type sp_cmd,
  input wire logic sp_op_erase,
  input wire logic [7:0] sp_wdata,
  output logic [7:0] sp_status,
  output logic [7:0] sp_protect,
  output logic sp_op_grant,
  output logic sp_op_to_config,
  output logic sp_erase_all,
  // Configuration page read port, one cycle latency
  output logic [8:0] cfg_addr,
  input wire logic [7:0] cfg_rdata,
  input wire logic [15:0] nv_top_bits,
  // Core side flash operations
  input wire logic core_op_done,
  output logic page_erase_req,
  output logic [7:0] page_erase_addr,
  // Flash write activity and brown-out
  input wire logic flash_write_busy,
  input wire logic brownout,
  output logic flash_abort,
  output logic chip_reset_req,
  // Derived controls
  output logic debug_enable,
  output logic [15:0] start_address,
  output logic reserve_top_bytes,
  output logic boot_done
);
  import fcr_pkg::*;

  parameter int PAGE_BYTES = 512;
  // Boundary field is 7 bits, so 128 pages must fit the 16 bit start address
  if (PAGE_BYTES < 1 || PAGE_BYTES * 128 > 65536) begin : g_page_check
    $error("PAGE_BYTES out of range");
  end

  typedef struct packed {
    fcr_boot_type boot;
    logic debug;
    logic start_from_protected;
    logic wen;
    logic ready_flag_n;
    logic redir;
    logic rbp;
    logic rsv0;
    logic [7:0] bound;
    logic [7:0] erase;
    logic erase_req;
    logic abort;
  } fcr_state_type;

  fcr_state_type st_r;
  fcr_state_type st_nxt;

  // Status byte assembled once, read by both ports
  function automatic logic [7:0] status_byte(input fcr_state_type s);
    logic [7:0] b;
    b = 8'h00;
    b[FCR_BIT_DEBUG] = s.debug;
    b[FCR_BIT_STP] = s.start_from_protected;
    b[FCR_BIT_WEN] = s.wen;
    b[FCR_BIT_READY_FLAG_N] = s.ready_flag_n;
    b[FCR_BIT_REDIR] = s.redir;
    b[FCR_BIT_RBP] = s.rbp;
    b[FCR_BIT_RSV1] = 1'b1;
    b[FCR_BIT_RSV0] = s.rsv0;
    return b;
  endfunction

  logic running;
  logic sp_go;
  assign running = (st_r.boot == FCR_BOOT_RUN);
  assign sp_go = sp_valid && running; // R23

  // ----------------------------------------------------------------
  // Boot readout, register writes and serial commands
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.erase_req = 1'b0;
    st_nxt.abort = 1'b0;
    case (st_r.boot)
      // One cycle read latency: RBP, DEBUG and WAIT each capture the byte addressed last cycle
      FCR_BOOT_BOUND: st_nxt.boot = FCR_BOOT_RBP;
      FCR_BOOT_RBP: begin
        st_nxt.bound = cfg_rdata; // R19
        st_nxt.boot = FCR_BOOT_DEBUG;
      end
      FCR_BOOT_DEBUG: begin
        st_nxt.rbp = (cfg_rdata != FCR_CFG_ERASED); // R21
        st_nxt.boot = FCR_BOOT_WAIT;
      end
      FCR_BOOT_WAIT: begin
        st_nxt.debug = (cfg_rdata != FCR_CFG_ERASED); // R20 R03
        st_nxt.start_from_protected = ^nv_top_bits; // R05
        st_nxt.ready_flag_n = 1'b0; // R09 R01
        st_nxt.boot = FCR_BOOT_RUN;
      end
      FCR_BOOT_RUN: begin
        // Core writes; read-only fields simply not assigned
        if (sfr_wr && sfr_addr == FCR_ADDR_STATUS) begin // R02 R22
          st_nxt.wen = sfr_wdata[FCR_BIT_WEN]; // R07
          st_nxt.redir = sfr_wdata[FCR_BIT_REDIR]; // R10
          st_nxt.rsv0 = sfr_wdata[FCR_BIT_RSV0];
          if (!st_r.rbp && sfr_wdata[FCR_BIT_DEBUG]) begin
            st_nxt.debug = 1'b1; // R04
          end
        end
        if (sfr_wr && sfr_addr == FCR_ADDR_ERASE) begin // R17
          st_nxt.erase = sfr_wdata;
          st_nxt.erase_req = (sfr_wdata < FCR_PAGE_LIMIT);
        end
        // Core operations leave the latch alone
        if (core_op_done) begin
          st_nxt.wen = st_nxt.wen; // R08
        end
        if (sp_go) begin
          case (sp_cmd)
            FCR_SP_WREN: st_nxt.wen = 1'b1;
            FCR_SP_WRDIS: st_nxt.wen = 1'b0;
            FCR_SP_STATUS_WRITE_COMMAND: begin
              // Debug and protect bits ignored here
              st_nxt.wen = sp_wdata[FCR_BIT_WEN]; // R14 R22
              st_nxt.redir = sp_wdata[FCR_BIT_REDIR];
            end
            FCR_SP_OP: begin
              if (sp_op_grant && sp_op_erase) begin
                st_nxt.wen = 1'b0; // R08
              end
            end
            FCR_SP_ERASE_ALL: begin
              if (st_r.wen) begin
                st_nxt.rbp = 1'b0; // R13 R11
                st_nxt.debug = 1'b0;
                st_nxt.bound = FCR_BOUNDARY_RESET;
                st_nxt.wen = 1'b0; // R08
              end
            end
            FCR_SP_SET_RBP: begin
              if (st_r.wen) begin
                st_nxt.rbp = 1'b1; // R14
                st_nxt.wen = 1'b0;
              end
            end
            FCR_SP_SET_DEBUG: begin
              if (st_r.wen) begin
                st_nxt.debug = 1'b1; // R14
                st_nxt.wen = 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
        // Serial writes (non-erase) also clear the latch
        if (sp_go && sp_cmd == FCR_SP_OP && sp_op_grant && !sp_op_erase) begin
          st_nxt.wen = 1'b0; // R08
        end
        if (brownout && flash_write_busy) begin
          st_nxt.abort = 1'b1; // R18
        end
      end
      default: st_nxt.boot = FCR_BOOT_BOUND;
    endcase
  end

  // ----------------------------------------------------------------
  // State register with documented reset values
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset || st_r.abort) begin
      st_r.boot <= FCR_BOOT_BOUND;
      st_r.debug <= 1'b0;
      st_r.start_from_protected <= 1'b0;
      st_r.wen <= 1'b0;
      st_r.ready_flag_n <= 1'b1;
      st_r.redir <= 1'b0;
      st_r.rbp <= 1'b1;
      st_r.rsv0 <= 1'b0;
      st_r.bound <= FCR_BOUNDARY_RESET;
      st_r.erase <= FCR_ERASE_RESET;
      st_r.erase_req <= 1'b0;
      st_r.abort <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Boot address walk; other states park on the boundary byte
  always_comb begin
    case (st_r.boot)
      FCR_BOOT_BOUND: cfg_addr = FCR_CFG_BOUNDARY;
      FCR_BOOT_RBP: cfg_addr = FCR_CFG_RBP;
      FCR_BOOT_DEBUG: cfg_addr = FCR_CFG_DEBUG;
      default: cfg_addr = FCR_CFG_BOUNDARY;
    endcase
  end

  // Reads of unmapped addresses return zero
  always_comb begin
    case (sfr_addr)
      FCR_ADDR_STATUS: sfr_rdata = status_byte(st_r);
      FCR_ADDR_PROTECT: sfr_rdata = st_r.bound; // R15
      FCR_ADDR_ERASE: sfr_rdata = st_r.erase;
      default: sfr_rdata = 8'h00;
    endcase
  end

  assign sp_status = status_byte(st_r);
  assign sp_protect = st_r.bound; // R15
  // Main block access refused under protection unless redirected to the page.
  // Page erases are refused too; other page ops are granted only while the latch is clear.
  assign sp_op_grant = sp_go && sp_cmd == FCR_SP_OP
    && (st_r.redir ? (!st_r.rbp || !sp_op_erase && !st_r.wen) : !st_r.rbp) // R12 R21
    && (st_r.wen || (!sp_op_erase && !st_r.wen)); // R07
  assign sp_op_to_config = st_r.redir; // R10
  assign sp_erase_all = sp_go && sp_cmd == FCR_SP_ERASE_ALL && st_r.wen; // R11
  assign page_erase_req = st_r.erase_req; // R17
  assign page_erase_addr = st_r.erase;
  assign flash_abort = st_r.abort; // R18
  assign chip_reset_req = st_r.abort; // R18
  assign debug_enable = st_r.debug; // R03
  // Start at boundary page only when enabled and a boundary is set
  assign start_address = (st_r.start_from_protected && st_r.bound != FCR_CFG_ERASED) ?
    16'(st_r.bound[6:0] * PAGE_BYTES) : 16'h0000; // R06
  assign reserve_top_bytes = running && st_r.bound < FCR_PAGE_LIMIT; // R16
  assign boot_done = running;
endmodule // fcr_flash_config

// *** sim/fcr_cfg_page_model.sv ***
`timescale 1ns/1ns
module fcr_cfg_page_model #(
  parameter logic [7:0] BOUNDARY = 8'h05,
  parameter logic [7:0] PROTECT = 8'hff,
  parameter logic [7:0] DEBUG = 8'hff,
  parameter logic [15:0] TOP_BITS = 16'h0001
) (
  input logic clk_sys,
  input logic [8:0] cfg_addr,
  output logic [7:0] cfg_rdata = 8'h00,
  output logic [15:0] nv_top_bits
);
  import fcr_pkg::*;
  logic [7:0] byte_nxt;
  // Unused bytes hold a filler no field expects, so a wrong address shows
  always_comb begin
    case (cfg_addr)
      FCR_CFG_BOUNDARY: byte_nxt = BOUNDARY;
      FCR_CFG_RBP: byte_nxt = PROTECT;
      FCR_CFG_DEBUG: byte_nxt = DEBUG;
      default: byte_nxt = 8'h5a;
    endcase
  end
  // Array answers one cycle after the address
  always @(posedge clk_sys) begin
    cfg_rdata <= byte_nxt;
  end
  assign nv_top_bits = TOP_BITS;
endmodule // fcr_cfg_page_model

// *** sim/fcr_flash_config_asserts.sv ***
`timescale 1ns/1ns
module fcr_flash_config_asserts #(
  parameter int PAGE_BYTES = 512
) (
  input logic clk_sys,
  input logic reset,
  input logic [7:0] sfr_addr,
  input logic sfr_wr,
  input logic [7:0] sfr_wdata,
  input logic [7:0] sfr_rdata,
  input logic sp_valid,
  input fcr_pkg::fcr_sp_cmd_type sp_cmd,
  input logic sp_op_erase,
  input logic [7:0] sp_status,
  input logic [7:0] sp_protect,
  input logic sp_op_grant,
  input logic sp_erase_all,
  input logic [15:0] nv_top_bits,
  input logic page_erase_req,
  input logic [7:0] page_erase_addr,
  input logic flash_write_busy,
  input logic brownout,
  input logic flash_abort,
  input logic chip_reset_req,
  input logic [15:0] start_address,
  input logic reserve_top_bytes,
  input logic boot_done
);
  import fcr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // --------------------------------------------------------------
  // Boot, core and serial operations
  // --------------------------------------------------------------
  sequence latch_op;
    sp_valid && sp_cmd == FCR_SP_OP && sp_op_grant && sp_status[5];
  endsequence
  sequence erase_req;
    sp_valid && sp_cmd == FCR_SP_OP && sp_op_erase;
  endsequence
  status_reset_a: assert property ($fell(reset) |-> sp_status == 8'h16 && !boot_done)
    else $error("status not at reset value");
  boot_time_a: assert property ($fell(reset) |-> ##[3:5] boot_done)
    else $error("boot readout late");
  ready_low_a: assert property (boot_done |-> !sp_status[4] && sp_status[6] == ^nv_top_bits)
    else $error("ready or start flag wrong");
  shared_view_a: assert property (sfr_addr == FCR_ADDR_STATUS |-> sfr_rdata == sp_status)
    else $error("views disagree");
  latch_clear_a: assert property (latch_op |=> !sp_status[5])
    else $error("latch kept after serial op");
  wen_gate_a: assert property (erase_req ##0 !sp_status[5] |-> !sp_op_grant)
    else $error("erase granted without latch");
  rbp_gate_a: assert property (erase_req ##0 sp_status[2] |-> !sp_op_grant)
    else $error("erase granted under protection");
  debug_keep_a: assert property (sp_status[7] && !sp_erase_all |=> sp_status[7] || !boot_done)
    else $error("debug flag cleared");
  // Any core write after boot to the erase register below the limit erases once
  page_erase_a: assert property (boot_done && sfr_wr && sfr_addr == FCR_ADDR_ERASE |=>
    page_erase_req == ($past(sfr_wdata) < FCR_PAGE_LIMIT)
    && (!page_erase_req || page_erase_addr == $past(sfr_wdata)))
    else $error("page erase wrong");
  brownout_a: assert property (boot_done && brownout && flash_write_busy |=> flash_abort
    && chip_reset_req)
    else $error("brownout not handled");
  reserve_a: assert property (boot_done |-> reserve_top_bytes == (sp_protect < FCR_PAGE_LIMIT))
    else $error("reserve flag wrong");
  start_a: assert property (boot_done && sp_status[6] && sp_protect != 8'hff |->
    start_address == 16'(sp_protect[6:0] * PAGE_BYTES))
    else $error("start address wrong");
endmodule // fcr_flash_config_asserts
bind fcr_flash_config fcr_flash_config_asserts #(.PAGE_BYTES(PAGE_BYTES)) asserts_inst (
  .clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sp_valid(sp_valid), .sp_cmd(sp_cmd),
  .sp_op_erase(sp_op_erase), .sp_status(sp_status), .sp_protect(sp_protect),
  .sp_op_grant(sp_op_grant), .sp_erase_all(sp_erase_all), .nv_top_bits(nv_top_bits),
  .page_erase_req(page_erase_req), .page_erase_addr(page_erase_addr),
  .flash_write_busy(flash_write_busy), .brownout(brownout), .flash_abort(flash_abort),
  .chip_reset_req(chip_reset_req), .start_address(start_address),
  .reserve_top_bytes(reserve_top_bytes), .boot_done(boot_done));

// *** sim/fcr_flash_config_bench.sv ***
`timescale 1ns/1ns
module fcr_flash_config_bench;
  import fcr_pkg::*;
  logic clk_sys, reset, sfr_wr, sp_valid, sp_op_erase, core_op_done, flash_write_busy;
  logic brownout, sp_op_grant, sp_op_to_config, sp_erase_all, page_erase_req, flash_abort;
  logic chip_reset_req, debug_enable, reserve_top_bytes, boot_done, g, ea;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, sp_wdata, sp_status, sp_protect, cfg_rdata;
  logic [7:0] page_erase_addr;
  logic [8:0] cfg_addr;
  logic [15:0] nv_top_bits, start_address;
  fcr_sp_cmd_type sp_cmd;
  int mismatches, n_compared;
  fcr_flash_config fcr_flash_config_inst (
    .clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sp_valid(sp_valid), .sp_cmd(sp_cmd),
    .sp_op_erase(sp_op_erase), .sp_wdata(sp_wdata), .sp_status(sp_status),
    .sp_protect(sp_protect), .sp_op_grant(sp_op_grant), .sp_op_to_config(sp_op_to_config),
    .sp_erase_all(sp_erase_all), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
    .nv_top_bits(nv_top_bits), .core_op_done(core_op_done), .page_erase_req(page_erase_req),
    .page_erase_addr(page_erase_addr), .flash_write_busy(flash_write_busy),
    .brownout(brownout), .flash_abort(flash_abort), .chip_reset_req(chip_reset_req),
    .debug_enable(debug_enable), .start_address(start_address),
    .reserve_top_bytes(reserve_top_bytes), .boot_done(boot_done));
  fcr_cfg_page_model fcr_cfg_page_model_inst (
    .clk_sys(clk_sys), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .nv_top_bits(nv_top_bits));
  // --------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task st(input logic [7:0] e);
    #1 chk(sp_status, e, "sp_status");
  endtask
  // Write is taken on the second edge, where the strobe drops
  task core_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wr <= 1'b1;
    sfr_wdata <= d;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  task core_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    sfr_addr <= a;
    #1 chk(sfr_rdata, e, "sfr_rdata");
  endtask
  // Grant and erase-all answer in the request cycle only
  task sp(input fcr_sp_cmd_type c, input logic e, input logic [7:0] d);
    @(posedge clk_sys);
    sp_valid <= 1'b1;
    sp_cmd <= c;
    sp_op_erase <= e;
    sp_wdata <= d;
    #1 g = sp_op_grant;
    ea = sp_erase_all;
    @(posedge clk_sys);
    sp_valid <= 1'b0;
  endtask
  task wait_boot;
    for (int i = 0; i < 20 && boot_done !== 1'b1; i++) @(posedge clk_sys);
    #1 chk(boot_done, 16'h1, "boot_done");
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Cut a hang short well past the expected run
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    test_done;
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {reset, sfr_wr, sp_valid, sp_op_erase, core_op_done, flash_write_busy, brownout} = 7'h40;
    {sfr_addr, sfr_wdata, sp_wdata} = 24'h000000;
    sp_cmd = FCR_SP_NONE;
    mismatches = 0;
    n_compared = 0;
    @(posedge clk_sys);
    st(8'h16);
    chk(sp_protect, 16'hff, "sp_protect");
    @(posedge clk_sys);
    reset <= 1'b0;
    sp(FCR_SP_WREN, 1'b0, 8'h00);
    wait_boot;
    st(8'h42);
    chk(sp_protect, 16'h05, "sp_protect");
    chk(start_address, 16'h0a00, "start_address");
    chk(reserve_top_bytes, 16'h1, "reserve_top_bytes");
    core_rd(FCR_ADDR_STATUS, 8'h42);
    core_wr(FCR_ADDR_PROTECT, 8'h00);
    core_rd(FCR_ADDR_PROTECT, 8'h05);
    core_wr(FCR_ADDR_STATUS, 8'hff);
    st(8'heb);
    chk(sp_op_to_config, 16'h1, "sp_op_to_config");
    chk(debug_enable, 16'h1, "debug_enable");
    @(posedge clk_sys);
    core_op_done <= 1'b1;
    @(posedge clk_sys);
    core_op_done <= 1'b0;
    st(8'heb);
    core_wr(FCR_ADDR_STATUS, 8'h00);
    st(8'hc2);
    sp(FCR_SP_WREN, 1'b0, 8'h00);
    st(8'he2);
    sp(FCR_SP_OP, 1'b1, 8'h00);
    chk(g, 16'h1, "sp_op_grant");
    st(8'hc2);
    sp(FCR_SP_OP, 1'b1, 8'h00);
    chk(g, 16'h0, "sp_op_grant");
    sp(FCR_SP_STATUS_WRITE_COMMAND, 1'b0, 8'h08);
    st(8'hca);
    sp(FCR_SP_SET_RBP, 1'b0, 8'h00);
    st(8'hca);
    sp(FCR_SP_WREN, 1'b0, 8'h00);
    sp(FCR_SP_SET_RBP, 1'b0, 8'h00);
    core_wr(FCR_ADDR_STATUS, 8'h20);
    #1 chk(sp_status[2], 16'h1, "readback_protect");
    sp(FCR_SP_OP, 1'b1, 8'h00);
    chk(g, 16'h0, "sp_op_grant");
    sp(FCR_SP_WREN, 1'b0, 8'h00);
    sp(FCR_SP_ERASE_ALL, 1'b0, 8'h00);
    chk(ea, 16'h1, "sp_erase_all");
    #1 chk(sp_status[2], 16'h0, "readback_protect");
    chk(sp_protect, 16'hff, "sp_protect");
    sp(FCR_SP_WREN, 1'b0, 8'h00);
    sp(FCR_SP_WRDIS, 1'b0, 8'h00);
    st(8'h42);
    sp(FCR_SP_WREN, 1'b0, 8'h00);
    sp(FCR_SP_SET_DEBUG, 1'b0, 8'h00);
    st(8'hc2);
    chk(debug_enable, 16'h1, "debug_enable");
    core_wr(FCR_ADDR_ERASE, 8'h23);
    #1 chk({page_erase_req, page_erase_addr}, 16'h123, "page_erase");
    core_rd(FCR_ADDR_ERASE, 8'h23);
    core_wr(FCR_ADDR_ERASE, 8'h24);
    #1 chk(page_erase_req, 16'h0, "page_erase_req");
    @(posedge clk_sys);
    {flash_write_busy, brownout} <= 2'b11;
    @(posedge clk_sys);
    {flash_write_busy, brownout} <= 2'b00;
    #1 chk({flash_abort, chip_reset_req}, 16'h3, "abort_reset");
    // The restart must really happen before the reboot is waited for
    @(posedge clk_sys);
    #1 chk(boot_done, 16'h0, "boot_done");
    st(8'h16);
    // A latch request during the reboot must be dropped
    sp(FCR_SP_WREN, 1'b0, 8'h00);
    wait_boot;
    st(8'h42);
    test_done;
  end
endmodule // fcr_flash_config_bench
